/* verilog/uxt_top.sv */
// uxt_top: apb register file, trigger requests and rs-485 direction control
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module uxt_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] tx_fifo_level,
    input wire logic [7:0] rx_fifo_level,
    input wire logic tx_busy,
    input wire logic bit_tick,
    input wire logic rts_modem,
    input wire logic dtr_modem,
    output logic tx_request,
    output logic rx_request,
    output logic flow_stop,
    output logic [3:0] prescale_value,
    output logic transmitter_off,
    output logic receiver_off,
    output logic multidrop_enable,
    output logic request_to_send_out,
    output logic terminal_ready_out,
    output logic irq
);
    typedef struct packed {
        logic [7:0] tx_trig;
        logic [7:0] rx_trig;
        logic [7:0] flow_high;
        logic [7:0] flow_low;
        logic [3:0] prescale;
        logic [7:0] turn_delay;
        logic [5:0] adv2;
        logic [3:0] status;
        logic [3:0] mask;
        logic [2:0] ev_prev;
        logic flow_hold;
        logic rts_pin;
        logic dtr_pin;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } uxt_top_state_type;

    uxt_top_state_type s_r;
    uxt_top_state_type s_nxt;

    logic tx_below;
    logic rx_reached;
    logic high_reached;
    logic low_below;
    logic turn_driving;
    logic turn_done;
    logic ctrl_active;
    logic access_end;
    logic [3:0] events;
    logic [3:0] rd_clear;
    logic dir_level;
    logic [31:0] rd_word;
    logic rd_hit;

    // direction control only acts in multidrop mode with transmitter ownership
    assign ctrl_active = s_r.adv2[uxt_pkg::BIT_MULTIDROP] // see R15
        && s_r.adv2[uxt_pkg::BIT_TX_OWNS]; // see R11

    uxt_level_cmp u_tx_cmp (
        .pclk(pclk),
        .presetn(presetn),
        .enable(!s_r.adv2[uxt_pkg::BIT_TX_OFF]), // see R13
        .fill(tx_fifo_level),
        .setting(s_r.tx_trig), // see R1
        .reached(),
        .below(tx_below)
    );

    uxt_level_cmp u_rx_cmp (
        .pclk(pclk),
        .presetn(presetn),
        .enable(!s_r.adv2[uxt_pkg::BIT_RX_OFF]), // see R14
        .fill(rx_fifo_level),
        .setting(s_r.rx_trig), // see R3
        .reached(rx_reached),
        .below()
    );

    uxt_level_cmp u_high_cmp (
        .pclk(pclk),
        .presetn(presetn),
        .enable(1'b1),
        .fill(rx_fifo_level),
        .setting(s_r.flow_high), // see R5
        .reached(high_reached),
        .below()
    );

    uxt_level_cmp u_low_cmp (
        .pclk(pclk),
        .presetn(presetn),
        .enable(1'b1),
        .fill(rx_fifo_level),
        .setting(s_r.flow_low), // see R6
        .reached(),
        .below(low_below)
    );

    uxt_turnaround u_turn (
        .pclk(pclk),
        .presetn(presetn),
        .active(ctrl_active),
        .tx_busy(tx_busy),
        .bit_tick(bit_tick),
        .delay(s_r.turn_delay),
        .driving(turn_driving),
        .done(turn_done)
    );

    // zero wait would need combinational prdata; one wait state keeps it a flop
    assign access_end = psel && penable && s_r.pready;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        if (paddr == uxt_pkg::OFS_TX_TRIG) begin
            rd_word[7:0] = s_r.tx_trig;
        end else if (paddr == uxt_pkg::OFS_RX_TRIG) begin
            rd_word[7:0] = s_r.rx_trig;
        end else if (paddr == uxt_pkg::OFS_FLOW_HIGH) begin
            rd_word[7:0] = s_r.flow_high;
        end else if (paddr == uxt_pkg::OFS_FLOW_LOW) begin
            rd_word[7:0] = s_r.flow_low;
        end else if (paddr == uxt_pkg::OFS_PRESCALE) begin
            rd_word[3:0] = s_r.prescale; // see R16
        end else if (paddr == uxt_pkg::OFS_TURNAROUND) begin
            rd_word[7:0] = s_r.turn_delay;
        end else if (paddr == uxt_pkg::OFS_ADV_CTRL2) begin
            rd_word[5:0] = s_r.adv2; // see R16
        end else if (paddr == uxt_pkg::OFS_IRQ_STATUS) begin
            rd_word[3:0] = s_r.status;
        end else if (paddr == uxt_pkg::OFS_IRQ_MASK) begin
            rd_word[3:0] = s_r.mask;
        end else if (paddr == uxt_pkg::OFS_LINE_STATE) begin
            rd_word[3:0] = {turn_driving, s_r.flow_hold, rx_reached, tx_below};
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_comb begin
        s_nxt = s_r;
        // bus handshake: pready rises in the second access cycle
        s_nxt.pready = psel && penable && !s_r.pready;
        if (s_nxt.pready) begin
            s_nxt.prdata = pwrite ? 32'h0000_0000 : rd_word;
            s_nxt.pslverr = !rd_hit;
        end else begin
            s_nxt.pslverr = 1'b0;
        end
        if (access_end && pwrite && rd_hit) begin
            if (paddr == uxt_pkg::OFS_TX_TRIG) begin
                s_nxt.tx_trig = pwdata[7:0]; // see R2
            end else if (paddr == uxt_pkg::OFS_RX_TRIG) begin
                s_nxt.rx_trig = pwdata[7:0]; // see R4
            end else if (paddr == uxt_pkg::OFS_FLOW_HIGH) begin
                s_nxt.flow_high = pwdata[7:0];
            end else if (paddr == uxt_pkg::OFS_FLOW_LOW) begin
                s_nxt.flow_low = pwdata[7:0];
            end else if (paddr == uxt_pkg::OFS_PRESCALE) begin
                s_nxt.prescale = pwdata[uxt_pkg::PRESCALE_W-1:0]; // see R7
            end else if (paddr == uxt_pkg::OFS_TURNAROUND) begin
                s_nxt.turn_delay = pwdata[7:0];
            end else if (paddr == uxt_pkg::OFS_ADV_CTRL2) begin
                s_nxt.adv2 = pwdata[uxt_pkg::ADV2_W-1:0]; // see R16
            end else if (paddr == uxt_pkg::OFS_IRQ_MASK) begin
                s_nxt.mask = pwdata[uxt_pkg::EV_W-1:0];
            end
        end
        // flow control hysteresis between the two thresholds
        if (high_reached) begin
            s_nxt.flow_hold = 1'b1; // see R5
        end else if (low_below) begin
            s_nxt.flow_hold = 1'b0; // see R6
        end
        // sticky events; a new event in the last cycle of the clearing read survives
        events = 4'h0;
        events[uxt_pkg::EV_TX] = tx_below && !s_r.ev_prev[0]; // see R1
        events[uxt_pkg::EV_RX] = rx_reached && !s_r.ev_prev[1]; // see R3
        events[uxt_pkg::EV_FLOW] = s_r.flow_hold && !s_r.ev_prev[2];
        events[uxt_pkg::EV_TURN] = turn_done;
        s_nxt.ev_prev = {s_r.flow_hold, rx_reached, tx_below};
        rd_clear = 4'h0;
        if (access_end && !pwrite && paddr == uxt_pkg::OFS_IRQ_STATUS) begin
            rd_clear = 4'hf;
        end
        s_nxt.status = (s_r.status & ~rd_clear) | events;
        s_nxt.irq = |(s_nxt.status & s_nxt.mask);
        // idle level is the receive level; polarity flips both levels
        dir_level = !turn_driving ^ s_r.adv2[uxt_pkg::BIT_POLARITY]; // see R10
        s_nxt.rts_pin = rts_modem;
        s_nxt.dtr_pin = dtr_modem;
        if (ctrl_active) begin
            if (s_r.adv2[uxt_pkg::BIT_DTR_SEL]) begin
                s_nxt.dtr_pin = dir_level; // see R12
            end else begin
                s_nxt.rts_pin = dir_level; // see R12
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.rts_pin <= uxt_pkg::PIN_RST;
            s_r.dtr_pin <= uxt_pkg::PIN_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign tx_request = tx_below;
    assign rx_request = rx_reached;
    assign flow_stop = s_r.flow_hold;
    assign prescale_value = s_r.prescale;
    assign transmitter_off = s_r.adv2[uxt_pkg::BIT_TX_OFF];
    assign receiver_off = s_r.adv2[uxt_pkg::BIT_RX_OFF];
    assign multidrop_enable = s_r.adv2[uxt_pkg::BIT_MULTIDROP];
    assign request_to_send_out = s_r.rts_pin;
    assign terminal_ready_out = s_r.dtr_pin;
    assign irq = s_r.irq;

    property p_prescale_wr;
        @(posedge pclk) disable iff (!presetn)
        (access_end && pwrite && paddr == uxt_pkg::OFS_PRESCALE)
            |=> prescale_value == $past(pwdata[3:0]);
    endproperty
    a_prescale_wr: assert property (p_prescale_wr) // see R7
        else $error("prescale must take the written low nibble");

    property p_ctrl_wr;
        @(posedge pclk) disable iff (!presetn)
        (access_end && pwrite && paddr == uxt_pkg::OFS_ADV_CTRL2)
            |=> transmitter_off == $past(pwdata[2]) && receiver_off == $past(pwdata[1]);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) // see R13
        else $error("disable bits must follow the control write");

    property p_rx_off;
        @(posedge pclk) disable iff (!presetn)
        receiver_off ##1 receiver_off |-> !rx_request;
    endproperty
    a_rx_off: assert property (p_rx_off) // see R14
        else $error("receiver off must silence receive requests");

    property p_dir_pin;
        @(posedge pclk) disable iff (!presetn)
        (ctrl_active && !s_r.adv2[uxt_pkg::BIT_DTR_SEL])
            |=> request_to_send_out
            == ($past(turn_driving) ~^ $past(s_r.adv2[uxt_pkg::BIT_POLARITY]));
    endproperty
    a_dir_pin: assert property (p_dir_pin) // see R10
        else $error("direction pin level disagrees with polarity");

    property p_no_control;
        @(posedge pclk) disable iff (!presetn)
        !s_r.adv2[uxt_pkg::BIT_TX_OWNS] |=> request_to_send_out == $past(rts_modem)
            && terminal_ready_out == $past(dtr_modem);
    endproperty
    a_no_control: assert property (p_no_control) // see R11
        else $error("pins must follow modem values without ownership");

    property p_flow;
        @(posedge pclk) disable iff (!presetn)
        high_reached |=> flow_stop;
    endproperty
    a_flow: assert property (p_flow) // see R5
        else $error("high threshold must raise flow stop");

    property p_reserved;
        @(posedge pclk) disable iff (!presetn)
        (s_r.pready && paddr == uxt_pkg::OFS_ADV_CTRL2 && !pwrite)
            |-> prdata[31:6] == 26'h0;
    endproperty
    a_reserved: assert property (p_reserved) // see R16
        else $error("reserved control bits must read as zero");

    property p_tx_off;
        @(posedge pclk) disable iff (!presetn)
        transmitter_off ##1 transmitter_off |-> !tx_request;
    endproperty
    a_tx_off: assert property (p_tx_off) // see R13
        else $error("tx off must silence tx requests");

    property p_tx_req;
        @(posedge pclk) disable iff (!presetn)
        (!transmitter_off && tx_fifo_level == 8'h00) |=> tx_request;
    endproperty
    a_tx_req: assert property (p_tx_req) // see R1
        else $error("empty tx fifo must request data");

    property p_rx_req;
        @(posedge pclk) disable iff (!presetn)
        (!receiver_off && rx_fifo_level >= 8'h80) |=> rx_request;
    endproperty
    a_rx_req: assert property (p_rx_req) // see R3
        else $error("full rx fifo must request service");

    property p_flow_low;
        @(posedge pclk) disable iff (!presetn)
        (!high_reached && low_below) |=> !flow_stop;
    endproperty
    a_flow_low: assert property (p_flow_low) // see R6
        else $error("low threshold must clear flow stop");

    property p_dtr_pin;
        @(posedge pclk) disable iff (!presetn)
        (ctrl_active && s_r.adv2[uxt_pkg::BIT_DTR_SEL])
            |=> terminal_ready_out
            == ($past(turn_driving) ~^ $past(s_r.adv2[uxt_pkg::BIT_POLARITY]));
    endproperty
    a_dtr_pin: assert property (p_dtr_pin) // see R10
        else $error("dtr direction level disagrees with polarity");

    property p_rts_free;
        @(posedge pclk) disable iff (!presetn)
        (ctrl_active && s_r.adv2[uxt_pkg::BIT_DTR_SEL])
            |=> request_to_send_out == $past(rts_modem);
    endproperty
    a_rts_free: assert property (p_rts_free) // see R12
        else $error("unselected rts must follow modem");

    property p_turn_event;
        @(posedge pclk) disable iff (!presetn)
        turn_done |=> s_r.status[uxt_pkg::EV_TURN];
    endproperty
    a_turn_event: assert property (p_turn_event) // see R9
        else $error("turnaround done must set its status bit");

    property p_prescale_rd;
        @(posedge pclk) disable iff (!presetn)
        (s_r.pready && paddr == uxt_pkg::OFS_PRESCALE && !pwrite)
            |-> prdata[31:4] == 28'h0;
    endproperty
    a_prescale_rd: assert property (p_prescale_rd) // see R16
        else $error("reserved prescale bits must read as zero");
endmodule : uxt_top

/* verilog/uxt_pkg.sv */
// uxt_pkg: register map, fields and reset values of the uart extended control block
// Functional notes
// R1: tx fill below trigger raises dma/irq request
// R2: tx trigger 0x00/0x01 means one, up to 128
// R3: rx fill at trigger raises dma/irq request
// R4: rx trigger uses same one-to-128 encoding
// R5: high threshold stops remote transmitter
// R6: low threshold restarts remote transmitter
// R7: prescale is low nibble, reset zero
// R8: after last bit, count down turnaround bit times
// R9: at zero, direction pin turns to receive
// R10: polarity bit 5 inverts direction levels
// R11: bit 4 lets transmitter own direction pin
// R12: bit 3 selects rts or dtr as direction pin
// R13: bit 2 set disables transmitter
// R14: bit 1 set disables receiver
// R15: bit 0 selects multidrop rs-485 mode
// R16: reserved bits ignore writes, read zero
package uxt_pkg;
    localparam logic [11:0] OFS_TX_TRIG = 12'h000;
    localparam logic [11:0] OFS_RX_TRIG = 12'h004;
    localparam logic [11:0] OFS_FLOW_HIGH = 12'h008;
    localparam logic [11:0] OFS_FLOW_LOW = 12'h00c;
    localparam logic [11:0] OFS_PRESCALE = 12'h010;
    localparam logic [11:0] OFS_TURNAROUND = 12'h014;
    localparam logic [11:0] OFS_ADV_CTRL2 = 12'h018;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h01c;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h020;
    localparam logic [11:0] OFS_LINE_STATE = 12'h024;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic PIN_RST = 1'b1;
    localparam int PRESCALE_W = 4;
    localparam int ADV2_W = 6;
    localparam int BIT_POLARITY = 5;
    localparam int BIT_TX_OWNS = 4;
    localparam int BIT_DTR_SEL = 3;
    localparam int BIT_TX_OFF = 2;
    localparam int BIT_RX_OFF = 1;
    localparam int BIT_MULTIDROP = 0;
    localparam int EV_W = 4;
    localparam int EV_TX = 0;
    localparam int EV_RX = 1;
    localparam int EV_FLOW = 2;
    localparam int EV_TURN = 3;
    localparam logic [7:0] LEVEL_MAX = 8'h80;

    // settings above 128 have no meaning; they clamp to the deepest level
    function automatic logic [7:0] decode_level(input logic [7:0] setting);
        if (setting == 8'h00) begin
            return 8'h01;
        end else if (setting > LEVEL_MAX) begin
            return LEVEL_MAX;
        end
        return setting;
    endfunction : decode_level
endpackage : uxt_pkg

/* verilog/uxt_level_cmp.sv */
// uxt_level_cmp: registered compare of a fifo fill level against a coded setting
`timescale 1ns/10ps
module uxt_level_cmp (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic [7:0] fill,
    input wire logic [7:0] setting,
    output logic reached,
    output logic below
);
    typedef struct packed {
        logic reached;
        logic below;
    } uxt_cmp_state_type;

    uxt_cmp_state_type s_r;
    uxt_cmp_state_type s_nxt;

    always_comb begin
        s_nxt.reached = enable && (fill >= uxt_pkg::decode_level(setting));
        s_nxt.below = enable && (fill < uxt_pkg::decode_level(setting));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reached = s_r.reached;
    assign below = s_r.below;

    property p_below;
        @(posedge pclk) disable iff (!presetn)
        (enable && setting <= 8'h01 && fill == 8'h00) |=> below && !reached;
    endproperty
    a_below: assert property (p_below) // see R2
        else $error("setting of zero or one must act as level one");

    property p_reached;
        @(posedge pclk) disable iff (!presetn)
        (enable && setting == 8'h80 && fill == 8'h80) ##1 (enable && fill == 8'h7f)
            |-> reached ##1 below;
    endproperty
    a_reached: assert property (p_reached) // see R4
        else $error("setting 0x80 must act as level 128");
endmodule : uxt_level_cmp

/* verilog/uxt_turnaround.sv */
// uxt_turnaround: direction control countdown after the last transmitted bit
`timescale 1ns/10ps
module uxt_turnaround (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic active,
    input wire logic tx_busy,
    input wire logic bit_tick,
    input wire logic [7:0] delay,
    output logic driving,
    output logic done
);
    typedef enum logic [1:0] {UXT_IDLE, UXT_SEND, UXT_COUNT} uxt_turn_mode_type;
    typedef struct packed {
        uxt_turn_mode_type mode;
        logic [7:0] cnt;
        logic driving;
        logic done;
    } uxt_turn_state_type;

    uxt_turn_state_type s_r;
    uxt_turn_state_type s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        case (s_r.mode)
            UXT_IDLE: begin
                if (active && tx_busy) begin
                    s_nxt.mode = UXT_SEND;
                end
            end
            UXT_SEND: begin
                if (!active) begin
                    s_nxt.mode = UXT_IDLE;
                end else if (!tx_busy) begin
                    s_nxt.mode = UXT_COUNT; // see R8
                    s_nxt.cnt = delay;
                end
            end
            default: begin
                // a new frame during the countdown keeps the line driven
                if (!active) begin
                    s_nxt.mode = UXT_IDLE;
                end else if (tx_busy) begin
                    s_nxt.mode = UXT_SEND;
                end else if (s_r.cnt == 8'h00) begin
                    s_nxt.mode = UXT_IDLE; // see R9
                    s_nxt.done = 1'b1;
                end else if (bit_tick) begin
                    s_nxt.cnt = s_r.cnt - 8'h01; // see R8
                end
            end
        endcase
        s_nxt.driving = (s_nxt.mode != UXT_IDLE);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign driving = s_r.driving;
    assign done = s_r.done;

    property p_count_hold;
        @(posedge pclk) disable iff (!presetn)
        (s_r.mode == UXT_COUNT && active && !tx_busy && s_r.cnt != 8'h00)
            |=> s_r.cnt == $past(s_r.cnt) - {7'h00, $past(bit_tick)};
    endproperty
    a_count_hold: assert property (p_count_hold) // see R8
        else $error("turnaround count must drop by one per bit time");

    property p_release;
        @(posedge pclk) disable iff (!presetn)
        (s_r.mode == UXT_COUNT && active && !tx_busy && s_r.cnt == 8'h00)
            |=> (!driving && done) ##1 !done;
    endproperty
    a_release: assert property (p_release) // see R9
        else $error("count of zero must release the line for one pulse");
endmodule : uxt_turnaround

/* testbench/uxt_transceiver_model.sv */
// uxt_transceiver_model: rs-485 line transceiver steered by the direction pin
`timescale 1ns/10ps
module uxt_transceiver_model (
    input wire logic dir_pin,
    input wire logic send_is_high,
    output logic driver_on,
    output logic line
);
    // no enable delay is modelled, so a late turnaround shows at the pin at once
    assign driver_on = send_is_high ? dir_pin : ~dir_pin;
    // a released bus rests at the fail-safe bias level
    assign line = driver_on ? 1'b0 : 1'b1;
endmodule : uxt_transceiver_model

/* testbench/uart_extended_thresholds_rs485_bench.sv */
// uart_extended_thresholds_rs485_bench: apb tests of triggers, thresholds and turnaround
`timescale 1ns/10ps
module uart_extended_thresholds_rs485_bench;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] tx_fifo_level;
    logic [7:0] rx_fifo_level;
    logic tx_busy;
    logic bit_tick;
    logic rts_modem;
    logic dtr_modem;
    logic tx_request;
    logic rx_request;
    logic flow_stop;
    logic [3:0] prescale_value;
    logic transmitter_off;
    logic receiver_off;
    logic multidrop_enable;
    logic request_to_send_out;
    logic terminal_ready_out;
    logic irq;
    logic driver_on;
    logic err_seen;
    logic [7:0] lev;
    logic [7:0] lv[4] = '{8'h00, 8'h01, 8'h05, 8'h80};
    logic [7:0] ff[5] = '{8'h7f, 8'h03, 8'h0f, 8'h10, 8'h04};
    logic [31:0] fe[5] = '{32'h1, 32'h0, 32'h0, 32'h1, 32'h1};
    int failures;
    int n_tests;

    uxt_top dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .tx_fifo_level(tx_fifo_level),
        .rx_fifo_level(rx_fifo_level),
        .tx_busy(tx_busy),
        .bit_tick(bit_tick),
        .rts_modem(rts_modem),
        .dtr_modem(dtr_modem),
        .tx_request(tx_request),
        .rx_request(rx_request),
        .flow_stop(flow_stop),
        .prescale_value(prescale_value),
        .transmitter_off(transmitter_off),
        .receiver_off(receiver_off),
        .multidrop_enable(multidrop_enable),
        .request_to_send_out(request_to_send_out),
        .terminal_ready_out(terminal_ready_out),
        .irq(irq)
    );

    // the rts pin steers the transceiver, low means send
    uxt_transceiver_model partner (
        .dir_pin(request_to_send_out),
        .send_is_high(1'b0),
        .driver_on(driver_on),
        .line()
    );

    task automatic summarize();
        if (failures == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    // starts one edge late so a release and a new setup never share a time step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            failures++;
        end
        q = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        check(nm, q, e);
    endtask : rd

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // the whole run needs about three hundred cycles
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        summarize();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        tx_fifo_level = 8'h00;
        rx_fifo_level = 8'h00;
        tx_busy = 1'b0;
        bit_tick = 1'b0;
        rts_modem = 1'b1;
        dtr_modem = 1'b1;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        tick(2);
        check("rts pin", 32'(request_to_send_out), 32'h1);
        for (int i = 0; i < 7; i++) rd(12'(4 * i), 32'h0, "reset value");
        rd(uxt_pkg::OFS_IRQ_MASK, 32'h0, "mask reset");
        rd(uxt_pkg::OFS_IRQ_STATUS, 32'h1, "status after reset");
        rd(uxt_pkg::OFS_IRQ_STATUS, 32'h0, "status cleared");
        rx_fifo_level <= 8'h01;
        tick(4);
        check("masked irq", 32'(irq), 32'h0);
        wr(uxt_pkg::OFS_IRQ_MASK, 32'hff);
        rd(uxt_pkg::OFS_IRQ_MASK, 32'hf, "mask");
        check("irq", 32'(irq), 32'h1);
        rd(uxt_pkg::OFS_LINE_STATE, 32'h7, "line state");
        rd(uxt_pkg::OFS_IRQ_STATUS, 32'h6, "status");
        tick(2);
        check("irq after clear", 32'(irq), 32'h0);
        wr(uxt_pkg::OFS_IRQ_MASK, 32'h0);
        rd(12'h028, 32'h0, "unmapped read");
        check("pslverr", 32'(err_seen), 32'h1);
        // each trigger setting at one below and at its decoded level
        foreach (lv[i]) begin
            lev = (lv[i] == 8'h00) ? 8'h01 : lv[i];
            wr(uxt_pkg::OFS_TX_TRIG, {24'h0, lv[i]});
            wr(uxt_pkg::OFS_RX_TRIG, {24'h0, lv[i]});
            rd(uxt_pkg::OFS_TX_TRIG, {24'h0, lv[i]}, "tx trigger");
            tx_fifo_level <= lev - 8'h01;
            rx_fifo_level <= lev - 8'h01;
            tick(3);
            check("tx_request below", 32'(tx_request), 32'h1);
            check("rx_request below", 32'(rx_request), 32'h0);
            tx_fifo_level <= lev;
            rx_fifo_level <= lev;
            tick(3);
            check("tx_request at", 32'(tx_request), 32'h0);
            check("rx_request at", 32'(rx_request), 32'h1);
        end
        wr(uxt_pkg::OFS_FLOW_HIGH, 32'h10);
        wr(uxt_pkg::OFS_FLOW_LOW, 32'h04);
        foreach (ff[i]) begin
            rx_fifo_level <= ff[i];
            tick(4);
            check("flow_stop", 32'(flow_stop), fe[i]);
        end
        wr(uxt_pkg::OFS_PRESCALE, 32'hffffffff);
        rd(uxt_pkg::OFS_PRESCALE, 32'hf, "prescale");
        check("prescale_value", 32'(prescale_value), 32'hf);
        tx_fifo_level <= 8'h00;
        rx_fifo_level <= 8'h80;
        wr(uxt_pkg::OFS_ADV_CTRL2, 32'hff);
        rd(uxt_pkg::OFS_ADV_CTRL2, 32'h3f, "control two");
        check("tx off", {29'h0, transmitter_off, tx_request, multidrop_enable}, 32'h5);
        check("rx off", {30'h0, receiver_off, rx_request}, 32'h2);
        wr(uxt_pkg::OFS_TURNAROUND, 32'h03);
        wr(uxt_pkg::OFS_ADV_CTRL2, 32'h11);
        rd(uxt_pkg::OFS_IRQ_STATUS, 32'h7, "status before turn");
        tx_busy <= 1'b1;
        tick(3);
        check("rts sending", 32'(request_to_send_out), 32'h0);
        check("driver on", 32'(driver_on), 32'h1);
        check("dtr unselected", 32'(terminal_ready_out), 32'h1);
        tx_busy <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            tick(3);
            check("rts counting", 32'(request_to_send_out), 32'h0);
            bit_tick <= 1'b1;
            tick(1);
            bit_tick <= 1'b0;
        end
        tick(4);
        check("rts released", 32'(request_to_send_out), 32'h1);
        check("driver off", 32'(driver_on), 32'h0);
        rd(uxt_pkg::OFS_IRQ_STATUS, 32'h8, "status turn done");
        // inverted polarity on the dtr pin with no delay
        wr(uxt_pkg::OFS_TURNAROUND, 32'h00);
        wr(uxt_pkg::OFS_ADV_CTRL2, 32'h39);
        rts_modem <= 1'b0;
        dtr_modem <= 1'b0;
        tx_busy <= 1'b1;
        tick(3);
        check("dtr sending", 32'(terminal_ready_out), 32'h1);
        check("rts follows modem", 32'(request_to_send_out), 32'h0);
        dtr_modem <= 1'b1;
        tx_busy <= 1'b0;
        tick(4);
        check("dtr released", 32'(terminal_ready_out), 32'h0);
        wr(uxt_pkg::OFS_ADV_CTRL2, 32'h01);
        rts_modem <= 1'b1;
        tx_busy <= 1'b1;
        tick(3);
        check("rts not owned", 32'(request_to_send_out), 32'h1);
        check("multidrop", 32'(multidrop_enable), 32'h1);
        tx_busy <= 1'b0;
        wr(uxt_pkg::OFS_ADV_CTRL2, 32'h00);
        tick(2);
        check("normal framing", 32'(multidrop_enable), 32'h0);
        summarize();
    end
endmodule : uart_extended_thresholds_rs485_bench
